/* pmir_defs.svh */
`ifndef PMIR_DEFS_SVH
`define PMIR_DEFS_SVH

// Channel count and register word width.
`define PMIR_NCH 8
`define PMIR_W 16

// Command codes seen on the command port.
`define PMIR_CMD_CLEAR_FAULTS 8'h03
`define PMIR_CMD_STORE_USER 8'h15
`define PMIR_CMD_RESTORE_USER 8'h16
`define PMIR_CMD_USER_WORD_A 8'hb0
`define PMIR_CMD_USER_WORD_B 8'hb1
`define PMIR_CMD_OEM_WORD 8'hb2
`define PMIR_CMD_USER_UNPAGED 8'hb3
`define PMIR_CMD_USER_PAGED 8'hb4
`define PMIR_CMD_RSV_WORD_A 8'hb5
`define PMIR_CMD_RSV_WORD_B 8'hb6
`define PMIR_CMD_DISCH_THR 8'hc9
`define PMIR_CMD_COMMON 8'hef
`define PMIR_CMD_IDENT 8'he7
`define PMIR_CMD_LOT 8'he8
`define PMIR_CMD_INFO 8'he9
`define PMIR_CMD_VOUT_MIN 8'hfb

// Field positions and fixed values.
`define PMIR_INFO_ECC_BIT 5
`define PMIR_COMMON_ONES 4'hf
`define PMIR_VMIN_RST 16'hffff
`define PMIR_COEFF_RST 16'hc080
`define PMIR_ONE_Q15 44'h00000008000
`define PMIR_Q15_SCALE 16'h8000

// Share clock held-low detection time and its cycle count at 20 MHz.
`define PMIR_CLK_MHZ 20
`define PMIR_SHCLK_LOW_NS 1000
`define PMIR_SHCLK_LOW_CYC ((`PMIR_SHCLK_LOW_NS * `PMIR_CLK_MHZ + 999) / 1000)

`endif

/* pmir_pkg.sv */
`include "pmir_defs.svh"

package pmir_pkg;

	// Complete register state of the block.
	typedef struct packed {
		logic [1:0] wp_s;
		logic [1:0] sc_s;
		logic [4:0] sc_cnt;
		logic sc_held;
		logic refresh;
		logic ecc_ok;
		logic busy_flag;
		logic [7:0] on;
		logic [7:0] dis_flag;
		logic [7:0] hold;
		logic [7:0][15:0] coeff;
		logic [7:0][15:0] vmin;
		logic [7:0][15:0] upage;
		logic [7:0][15:0] upage_ee;
		logic [15:0] uword;
		logic [15:0] uword_ee;
		logic [15:0] oem;
		logic [15:0] oem_ee;
		logic [15:0] word_a;
		logic [15:0] word_b;
		logic [15:0] rsv_a;
		logic [15:0] rsv_b;
		logic rsp_valid;
		logic rsp_nack;
		logic [15:0] rsp_data;
		logic alert_o;
		logic alert_oe;
	} pmir_state_t;

endpackage

/* pmir_regs.sv */
`include "pmir_defs.svh"

module pmir_regs #(
	parameter logic [15:0] IDENT_CODE = 16'h5a3c, // Arbitrary neutral value.
	parameter logic [63:0] LOT_BYTES = {8{8'h01}} // Factory lot byte per page.
) (
	input wire logic ref_clk, // System clock, 20 MHz.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic cmd_valid, // Command strobe, one cycle.
	input wire logic cmd_write, // High for a write, low for a read.
	input wire logic [7:0] cmd_code, // Command code.
	input wire logic [2:0] cmd_page, // Page that the command addresses.
	input wire logic [15:0] cmd_wdata, // Write data.
	output logic rsp_valid, // Answer strobe, one cycle.
	output logic rsp_nack, // Command refused.
	output logic [15:0] rsp_data, // Read data.
	input wire logic dev_busy, // Device busy with EEPROM or other work.
	input wire logic ee_bulk_read, // EEPROM bulk read finished, one cycle.
	input wire logic ee_corrected, // ECC made corrections in user space.
	input wire logic wp_pin, // Write-protect pin.
	input wire logic share_clk_pin, // Share clock pin.
	output logic alert_o, // Alert pin drive value.
	output logic alert_oe, // Alert pin drive enable.
	input wire logic [7:0] chan_on_req, // Channel commanded on, level.
	input wire logic [127:0] vout_cmd_all, // Commanded output per channel.
	input wire logic [127:0] vout_meas_all, // Measured output per channel.
	input wire logic [7:0] vout_upd, // New measurement per channel, pulse.
	input wire logic [7:0] uv_det_en, // Undervoltage detection enabled.
	input wire logic [7:0] odd_is_current, // Channel measures current.
	output logic [7:0] chan_on, // Channel allowed in ON state.
	output logic [7:0] dis_flag, // Discharge status flag per channel.
	output logic busy_flag // Busy status flag for status byte and word.
);

	////////////////////////////////////////////////////////////////////////////////
	// Threshold arithmetic.

	// Multiplies an L11 coefficient by a 16-bit value, negative results clamp to zero.
	function automatic logic [43:0] l11_mul(input logic [15:0] c, input logic [15:0] v);
		logic signed [10:0] m;
		logic signed [4:0] e;
		logic signed [27:0] p;
		logic [43:0] r;
		m = c[10:0];
		e = c[15:11];
		p = m * $signed({1'b0, v});
		r = p[27] ? 44'h00000000000 : {16'h0000, p};
		if (e[4]) begin
			r = r >> (5'h00 - e);
		end else begin
			r = r << e;
		end
		return r;
	endfunction

	pmir_pkg::pmir_state_t q;
	pmir_pkg::pmir_state_t d;
	logic [7:0] below;
	logic [7:0] chk_off;

	// Per channel comparison of the output against its OFF threshold.
	for (genvar g = 0; g < `PMIR_NCH; g++) begin : g_thr
		assign below[g] = {28'h0000000, vout_meas_all[g*16 +: 16]} <
			l11_mul(q.coeff[g], vout_cmd_all[g*16 +: 16]);
		assign chk_off[g] = l11_mul(q.coeff[g], `PMIR_Q15_SCALE) > `PMIR_ONE_Q15;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	// Pin synchronisers, command decoding and per channel tracking.
	always_comb begin
		logic [2:0] pg;
		logic [15:0] meas;
		pg = cmd_page;
		meas = 16'h0000;
		d = q;
		d.wp_s = {q.wp_s[0], wp_pin};
		d.sc_s = {q.sc_s[0], share_clk_pin};
		d.rsp_valid = 1'b0;
		d.rsp_nack = 1'b0;
		d.refresh = 1'b0;
		d.alert_o = 1'b0;

		// A share clock low for 20 cycles (1000 ns at 20 MHz) or more counts as held low.
		if (q.sc_s[1]) begin
			d.sc_cnt = 5'h00;
		end else if (q.sc_cnt != 5'h1f) begin
			d.sc_cnt = q.sc_cnt + 5'h01;
		end
		d.sc_held = q.sc_cnt >= 5'(`PMIR_SHCLK_LOW_CYC);

		// The ECC status is sampled once after reset and after each bulk read.
		if (q.refresh || ee_bulk_read) begin
			d.ecc_ok = !ee_corrected;
		end

		// Command handling; the answer appears one cycle after the strobe.
		if (cmd_valid) begin
			d.rsp_valid = 1'b1;
			d.rsp_data = 16'h0000;
			if (dev_busy && !(cmd_code == `PMIR_CMD_COMMON && !cmd_write)) begin
				d.rsp_nack = 1'b1;
				d.busy_flag = 1'b1;
			end else if (cmd_code == `PMIR_CMD_CLEAR_FAULTS) begin
				d.dis_flag[pg] = 1'b0;
				d.vmin[pg] = `PMIR_VMIN_RST;
				d.busy_flag = 1'b0;
			end else if (cmd_code == `PMIR_CMD_STORE_USER) begin
				d.uword_ee = q.uword;
				d.oem_ee = q.oem;
				d.upage_ee = q.upage;
			end else if (cmd_code == `PMIR_CMD_RESTORE_USER) begin
				d.uword = q.uword_ee;
				d.oem = q.oem_ee;
				d.upage = q.upage_ee;
				d.ecc_ok = !ee_corrected;
			end else if (cmd_code == `PMIR_CMD_IDENT) begin
				d.rsp_data = IDENT_CODE;
			end else if (cmd_code == `PMIR_CMD_LOT) begin
				d.rsp_data = {8'h00, LOT_BYTES[pg*8 +: 8]};
			end else if (cmd_code == `PMIR_CMD_INFO) begin
				d.rsp_data[`PMIR_INFO_ECC_BIT] = q.ecc_ok;
			end else if (cmd_code == `PMIR_CMD_DISCH_THR) begin
				if (cmd_write) begin
					d.coeff[pg] = cmd_wdata;
				end
				d.rsp_data = q.coeff[pg];
			end else if (cmd_code == `PMIR_CMD_COMMON) begin
				d.rsp_data[7] = !q.alert_oe;
				d.rsp_data[6] = !dev_busy;
				d.rsp_data[5:2] = `PMIR_COMMON_ONES;
				d.rsp_data[1] = q.sc_held;
				d.rsp_data[0] = q.wp_s[1];
			end else if (cmd_code == `PMIR_CMD_USER_WORD_A) begin
				if (cmd_write) begin
					d.word_a = cmd_wdata;
				end
				d.rsp_data = q.word_a;
			end else if (cmd_code == `PMIR_CMD_USER_WORD_B) begin
				if (cmd_write) begin
					d.word_b = cmd_wdata;
				end
				d.rsp_data = q.word_b;
			end else if (cmd_code == `PMIR_CMD_OEM_WORD) begin
				if (cmd_write) begin
					d.oem = cmd_wdata;
				end
				d.rsp_data = q.oem;
			end else if (cmd_code == `PMIR_CMD_USER_UNPAGED) begin
				if (cmd_write) begin
					d.uword = cmd_wdata;
				end
				d.rsp_data = q.uword;
			end else if (cmd_code == `PMIR_CMD_USER_PAGED) begin
				if (cmd_write) begin
					d.upage[pg] = cmd_wdata;
				end
				d.rsp_data = q.upage[pg];
			end else if (cmd_code == `PMIR_CMD_RSV_WORD_A) begin
				if (cmd_write) begin
					d.rsv_a = cmd_wdata;
				end
				d.rsp_data = q.rsv_a;
			end else if (cmd_code == `PMIR_CMD_RSV_WORD_B) begin
				if (cmd_write) begin
					d.rsv_b = cmd_wdata;
				end
				d.rsp_data = q.rsv_b;
			end else if (cmd_code == `PMIR_CMD_VOUT_MIN) begin
				if (pg[0] && odd_is_current[pg]) begin
					d.rsp_nack = 1'b1;
				end else begin
					d.rsp_data = q.vmin[pg];
				end
			end else begin
				d.rsp_nack = 1'b1;
			end
		end

		// Channel gating and minimum tracking; flag sets override a clear in the same cycle.
		for (int c = 0; c < `PMIR_NCH; c++) begin
			meas = vout_meas_all[c*16 +: 16];
			if (!chan_on_req[c]) begin
				d.on[c] = 1'b0;
				d.hold[c] = 1'b0;
			end else if (!q.on[c]) begin
				if (chk_off[c] || below[c]) begin
					d.on[c] = 1'b1;
					d.hold[c] = 1'b0;
				end else begin
					d.hold[c] = 1'b1;
					if (!q.hold[c]) begin
						d.dis_flag[c] = 1'b1;
					end
				end
			end
			if (d.on[c] && !q.on[c]) begin
				d.vmin[c] = `PMIR_VMIN_RST;
			end else if (vout_upd[c] && uv_det_en[c] && !(c[0] && odd_is_current[c])) begin
				if (meas < d.vmin[c]) begin
					d.vmin[c] = meas;
				end
			end
		end
		d.alert_oe = |d.dis_flag;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	// Reset loads documented defaults and schedules the information refresh.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			q <= '0;
			q.refresh <= 1'b1;
			q.ecc_ok <= 1'b1;
			q.sc_s <= 2'h3;
			q.wp_s <= 2'h0;
			q.coeff <= {`PMIR_NCH{`PMIR_COEFF_RST}};
			q.vmin <= {`PMIR_NCH{`PMIR_VMIN_RST}};
		end else begin
			q <= d;
		end
	end

	// Outputs come straight from the state register.
	assign rsp_valid = q.rsp_valid;
	assign rsp_nack = q.rsp_nack;
	assign rsp_data = q.rsp_data;
	assign alert_o = q.alert_o;
	assign alert_oe = q.alert_oe;
	assign chan_on = q.on;
	assign dis_flag = q.dis_flag;
	assign busy_flag = q.busy_flag;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	logic rd_ok;
	assign rd_ok = cmd_valid && !cmd_write && !dev_busy;

	a_ident_fixed: assert property (rd_ok && cmd_code == `PMIR_CMD_IDENT |=>
		rsp_valid && !rsp_nack && rsp_data == IDENT_CODE)
		else $error("identity word wrong");

	a_lot_byte: assert property (rd_ok && cmd_code == `PMIR_CMD_LOT |=>
		rsp_data == {8'h00, LOT_BYTES[$past(cmd_page)*8 +: 8]})
		else $error("lot byte wrong");

	a_info_refresh: assert property (ee_bulk_read |=> q.ecc_ok == !$past(ee_corrected))
		else $error("ecc status not refreshed");

	a_info_bit: assert property (rd_ok && cmd_code == `PMIR_CMD_INFO |=>
		rsp_data == {10'h000, $past(q.ecc_ok), 5'h00})
		else $error("info word layout wrong");

	a_disch_flag: assert property (chan_on_req[0] && !chan_on[0] && !q.hold[0] &&
		!below[0] && !chk_off[0] |=> dis_flag[0] && alert_oe)
		else $error("discharge flag or alert missing");

	a_hold_off: assert property (chan_on_req[0] && !chan_on[0] && !below[0] && !chk_off[0]
		|=> !chan_on[0])
		else $error("channel entered on above threshold");

	a_check_off: assert property (chan_on_req[1] && !chan_on[1] && chk_off[1] |=>
		chan_on[1] && $stable(dis_flag[1]))
		else $error("disabled check still blocked on");

	a_common_read: assert property (cmd_valid && !cmd_write && cmd_code == `PMIR_CMD_COMMON |=>
		!rsp_nack && rsp_data[5:2] == `PMIR_COMMON_ONES && rsp_data[6] == !$past(dev_busy) &&
		rsp_data[7] == !$past(alert_oe) && rsp_data[0] == $past(q.wp_s[1]))
		else $error("common status read wrong");

	a_busy_nack: assert property (cmd_valid && dev_busy && cmd_code != `PMIR_CMD_COMMON |=>
		rsp_nack && busy_flag)
		else $error("busy command not refused");

	a_store_back: assert property (cmd_valid && !dev_busy && cmd_code == `PMIR_CMD_RESTORE_USER |=>
		q.uword == $past(q.uword_ee) && q.oem == $past(q.oem_ee))
		else $error("restore did not reload scratchpad");

	a_vmin_reset: assert property (chan_on[0] && !$past(chan_on[0]) |->
		q.vmin[0] == `PMIR_VMIN_RST)
		else $error("minimum not reset on turn on");

	a_vmin_hold: assert property (vout_upd[0] && !uv_det_en[0] && !(cmd_valid &&
		cmd_code == `PMIR_CMD_CLEAR_FAULTS) && !(chan_on_req[0] && !chan_on[0]) |=> $stable(q.vmin[0]))
		else $error("minimum changed while detection off");

	a_vmin_unsup: assert property (rd_ok && cmd_code == `PMIR_CMD_VOUT_MIN && cmd_page[0] &&
		odd_is_current[cmd_page] |=> rsp_nack)
		else $error("current channel minimum not refused");

	a_ro_ignore: assert property (cmd_valid && cmd_write && !dev_busy && cmd_code == `PMIR_CMD_INFO &&
		!ee_bulk_read && !q.refresh |=> !rsp_nack && $stable(q.ecc_ok))
		else $error("read-only write changed state");

	c_disch_wait: cover property (q.hold[0] ##[1:200] chan_on[0]);
	c_busy_poll: cover property (busy_flag ##1 rsp_valid && !rsp_nack && rsp_data[6] == 1'b0);
	c_vmin_track: cover property (vout_upd[0] ##1 q.vmin[0] != `PMIR_VMIN_RST);

endmodule

/* pmir_far_end.sv */
// Far side of the block: the power stage measurements and the share clock source.
module pmir_far_end (
	input wire logic ref_clk, // System clock, used to time measurement updates.
	input wire logic share_run, // High lets the share clock toggle.
	output logic share_clk_pin, // Share clock seen by the block.
	output logic [127:0] vout_meas_all, // Measured output per channel.
	output logic [7:0] vout_upd // New measurement pulse per channel.
);
	timeunit 1ns;
	timeprecision 100ps;

	////////////////////////////////////////////////////////////////////////////////
	// Share clock of 400 ns with its own phase; it parks low when stopped so the block can see it held.
	initial begin
		share_clk_pin = 1'b0;
		vout_meas_all = '0;
		vout_upd = '0;
		#7;
		forever begin
			#200;
			share_clk_pin = share_run ? ~share_clk_pin : 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Presents a new output level on one channel, with an update pulse when asked.
	task automatic sample(input int ch, input logic [15:0] v, input logic pulse);
		@(posedge ref_clk);
		#2;
		vout_meas_all[16*ch+:16] = v;
		vout_upd[ch] = pulse;
		@(posedge ref_clk);
		#2;
		vout_upd = '0;
	endtask
endmodule

/* pmir_regs_tb_top.sv */
`include "pmir_defs.svh"

// Counts one comparison and reports a mismatch at once.
`define PMIR_CHK(got, exp) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("[FAIL] %0t: got %h, expected %h", $time, (got), (exp)); \
	end \
end

module pmir_regs_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic [7:0] cmd_code = 8'h00;
	logic [2:0] cmd_page = 3'h0;
	logic [15:0] cmd_wdata = 16'h0000;
	logic rsp_valid;
	logic rsp_nack;
	logic [15:0] rsp_data;
	logic dev_busy = 1'b0;
	logic ee_bulk_read = 1'b0;
	logic ee_corrected = 1'b0;
	logic wp_pin = 1'b1;
	logic share_run = 1'b1;
	logic share_clk_pin;
	logic alert_o;
	logic alert_oe;
	logic [7:0] chan_on_req = 8'h00;
	logic [127:0] vout_meas_all;
	logic [7:0] vout_upd;
	logic [7:0] uv_det_en = 8'hff;
	logic [7:0] odd_is_current = 8'h00;
	logic [7:0] chan_on;
	logic [7:0] dis_flag;
	logic busy_flag;
	logic [15:0] rdata;
	logic rnack;
	int miscompares = 0;
	int tests_run = 0;
	logic [7:0] sc_code [4] = '{`PMIR_CMD_USER_UNPAGED, `PMIR_CMD_USER_PAGED, `PMIR_CMD_USER_PAGED, `PMIR_CMD_OEM_WORD};
	logic [2:0] sc_page [4] = '{3'h0, 3'h3, 3'h5, 3'h0};
	logic [15:0] sc_val [4] = '{16'h1234, 16'habcd, 16'h5555, 16'h0e0e};
	logic [7:0] mw_code [4] = '{`PMIR_CMD_USER_WORD_A, `PMIR_CMD_USER_WORD_B, `PMIR_CMD_RSV_WORD_A, `PMIR_CMD_RSV_WORD_B};

	////////////////////////////////////////////////////////////////////////////////
	// Clock of 50 ns and the two sides of the block.
	always #25 ref_clk = ~ref_clk;

	pmir_regs pmir_regs_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
		.rsp_nack(rsp_nack), .rsp_data(rsp_data), .dev_busy(dev_busy), .ee_bulk_read(ee_bulk_read),
		.ee_corrected(ee_corrected), .wp_pin(wp_pin), .share_clk_pin(share_clk_pin), .alert_o(alert_o),
		.alert_oe(alert_oe), .chan_on_req(chan_on_req), .vout_cmd_all({8{16'h2000}}),
		.vout_meas_all(vout_meas_all), .vout_upd(vout_upd), .uv_det_en(uv_det_en),
		.odd_is_current(odd_is_current), .chan_on(chan_on), .dis_flag(dis_flag), .busy_flag(busy_flag));

	pmir_far_end pmir_far_end_i (.ref_clk(ref_clk), .share_run(share_run), .share_clk_pin(share_clk_pin),
		.vout_meas_all(vout_meas_all), .vout_upd(vout_upd));

	////////////////////////////////////////////////////////////////////////////////
	// Prints the verdict and ends the run.
	task automatic close_out();
		if (miscompares == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// One command on the command port; the answer must come on the next edge.
	task automatic xfer(input logic w, input logic [7:0] code, input logic [2:0] pg, input logic [15:0] wd);
		@(posedge ref_clk);
		#2;
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_code = code;
		cmd_page = pg;
		cmd_wdata = wd;
		@(posedge ref_clk);
		#2;
		cmd_valid = 1'b0;
		rdata = rsp_data;
		rnack = rsp_nack;
		`PMIR_CHK(rsp_valid, 1'b1)
	endtask

	// Lets some clock edges pass and lands just after the last.
	task automatic cycles(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask

	// Waits a bounded time for a channel to be let into ON.
	task automatic wait_on(input int ch);
		int n;
		n = 0;
		while (chan_on[ch] !== 1'b1 && n < 40) begin
			@(posedge ref_clk);
			#2;
			n++;
		end
		`PMIR_CHK(chan_on[ch], 1'b1)
		if (n >= 40) close_out();
	endtask

	// Cuts a hung run short.
	initial begin
		#2000000;
		miscompares++;
		close_out();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (3) @(posedge ref_clk);
		#2;
		sys_rst = 1'b0;
		cycles(4);
		xfer(0, `PMIR_CMD_COMMON, 0, 0);
		`PMIR_CHK(rdata, 16'h00fd)
		xfer(0, `PMIR_CMD_VOUT_MIN, 3'h6, 0);
		`PMIR_CHK(rdata, 16'hffff)
		wp_pin = 1'b0;
		cycles(4);
		xfer(0, `PMIR_CMD_COMMON, 0, 0);
		`PMIR_CHK(rdata, 16'h00fc)
		share_run = 1'b0;
		cycles(30);
		xfer(0, `PMIR_CMD_COMMON, 0, 0);
		`PMIR_CHK(rdata, 16'h00fe)
		share_run = 1'b1;
		cycles(10);
		// Identity and lot are fixed, and a write to the identity leaves it alone.
		xfer(1, `PMIR_CMD_IDENT, 0, 16'hffff);
		xfer(0, `PMIR_CMD_IDENT, 0, 0);
		`PMIR_CHK(rdata, 16'h5a3c)
		xfer(0, `PMIR_CMD_LOT, 3'h7, 0);
		`PMIR_CHK(rdata, 16'h0001)
		// While busy only the common status is answered.
		dev_busy = 1'b1;
		xfer(0, `PMIR_CMD_IDENT, 0, 0);
		`PMIR_CHK(rnack, 1'b1)
		xfer(0, `PMIR_CMD_COMMON, 0, 0);
		`PMIR_CHK({rnack, rdata}, 17'h000bc)
		dev_busy = 1'b0;
		cycles(1);
		`PMIR_CHK(busy_flag, 1'b1)
		// A bulk read with corrections clears the ECC bit, and a write to the word leaves it alone.
		xfer(0, `PMIR_CMD_INFO, 0, 0);
		`PMIR_CHK(rdata, 16'h0020)
		ee_corrected = 1'b1;
		ee_bulk_read = 1'b1;
		cycles(1);
		ee_bulk_read = 1'b0;
		xfer(1, `PMIR_CMD_INFO, 0, 16'hffff);
		xfer(0, `PMIR_CMD_INFO, 0, 0);
		`PMIR_CHK(rdata, 16'h0000)
		ee_corrected = 1'b0;
		// Manufacturer words read back what was written.
		for (int i = 0; i < 4; i++) begin
			xfer(1, mw_code[i], 0, sc_val[i]);
			xfer(0, mw_code[i], 0, 0);
			`PMIR_CHK(rdata, sc_val[i])
		end
		// Scratch words survive an overwrite through store and restore.
		for (int i = 0; i < 4; i++) xfer(1, sc_code[i], sc_page[i], sc_val[i]);
		xfer(1, `PMIR_CMD_STORE_USER, 0, 0);
		for (int i = 0; i < 4; i++) xfer(1, sc_code[i], sc_page[i], 16'h0000);
		xfer(1, `PMIR_CMD_RESTORE_USER, 0, 0);
		xfer(0, `PMIR_CMD_INFO, 0, 0);
		`PMIR_CHK(rdata, 16'h0020)
		for (int i = 0; i < 4; i++) begin
			xfer(0, sc_code[i], sc_page[i], 0);
			`PMIR_CHK(rdata, sc_val[i])
		end
		// Channel 0 keeps the 0.5 coefficient, channel 1 gets 2.0 which turns the check off.
		xfer(0, `PMIR_CMD_DISCH_THR, 0, 0);
		`PMIR_CHK(rdata, 16'hc080)
		xfer(1, `PMIR_CMD_DISCH_THR, 3'h1, 16'h0002);
		xfer(0, `PMIR_CMD_DISCH_THR, 3'h1, 0);
		`PMIR_CHK(rdata, 16'h0002)
		pmir_far_end_i.sample(0, 16'h2000, 1'b0);
		pmir_far_end_i.sample(1, 16'h2000, 1'b0);
		chan_on_req = 8'h03;
		cycles(3);
		`PMIR_CHK({dis_flag, alert_oe}, 9'h003)
		`PMIR_CHK({alert_o, alert_oe}, 2'b01)
		`PMIR_CHK(chan_on[1:0], 2'b10)
		xfer(0, `PMIR_CMD_COMMON, 0, 0);
		`PMIR_CHK(rdata, 16'h007c)
		pmir_far_end_i.sample(0, 16'h0800, 1'b0);
		wait_on(0);
		// Minimum tracking on channel 0.
		xfer(0, `PMIR_CMD_VOUT_MIN, 0, 0);
		`PMIR_CHK(rdata, 16'hffff)
		pmir_far_end_i.sample(0, 16'h0800, 1'b1);
		pmir_far_end_i.sample(0, 16'h0c00, 1'b1);
		xfer(0, `PMIR_CMD_VOUT_MIN, 0, 0);
		`PMIR_CHK(rdata, 16'h0800)
		uv_det_en = 8'hfe;
		pmir_far_end_i.sample(0, 16'h0100, 1'b1);
		xfer(0, `PMIR_CMD_VOUT_MIN, 0, 0);
		`PMIR_CHK(rdata, 16'h0800)
		uv_det_en = 8'hff;
		xfer(1, `PMIR_CMD_CLEAR_FAULTS, 0, 0);
		xfer(0, `PMIR_CMD_VOUT_MIN, 0, 0);
		`PMIR_CHK(rdata, 16'hffff)
		`PMIR_CHK({dis_flag[0], alert_oe, busy_flag}, 3'b000)
		odd_is_current = 8'h02;
		xfer(0, `PMIR_CMD_VOUT_MIN, 3'h1, 0);
		`PMIR_CHK(rnack, 1'b1)
		close_out();
	end
endmodule
